// *** shared/pbr_pkg.sv ***
// Constants for the basic control and status register bank
package pbr_pkg;

  // ==========================================================================
  // Register addresses on the management port
  localparam logic [4:0]  PBR_ADDR_CONTROL   = 5'h00;
  localparam logic [4:0]  PBR_ADDR_STATUS    = 5'h01;

  // ==========================================================================
  // Control register fields
  localparam int          PBR_C_SOFT_RESET   = 15;
  localparam int          PBR_C_LOOPBACK     = 14;
  localparam int          PBR_C_SPEED_LSB    = 13;
  localparam int          PBR_C_NEG_ENABLE   = 12;
  localparam int          PBR_C_POWER_DOWN   = 11;
  localparam int          PBR_C_ISOLATE      = 10;
  localparam int          PBR_C_NEG_RESTART  = 9;
  localparam int          PBR_C_DUPLEX       = 8;
  localparam int          PBR_C_COL_TEST     = 7;
  localparam int          PBR_C_SPEED_MSB    = 6;
  localparam logic [15:0] PBR_CONTROL_RESET  = 16'h1140;
  localparam logic [15:0] PBR_CONTROL_WMASK  = 16'h7580;

  // ==========================================================================
  // Status register fields
  localparam int          PBR_S_NEG_DONE     = 5;
  localparam int          PBR_S_REMOTE_FAULT = 4;
  localparam int          PBR_S_LINK_UP      = 2;
  localparam int          PBR_S_JABBER       = 1;
  localparam logic [15:0] PBR_STATUS_RESET   = 16'h7949;
  localparam logic [15:0] PBR_STATUS_FIXED   = 16'h7949;

  // ==========================================================================
  // Speed codes
  localparam logic [1:0]  PBR_SPEED_10       = 2'h0;
  localparam logic [1:0]  PBR_SPEED_100      = 2'h1;
  localparam logic [1:0]  PBR_SPEED_1000     = 2'h2;
  localparam logic [1:0]  PBR_SPEED_RSVD     = 2'h3;

  // ==========================================================================
  // Timing
  localparam int          PBR_CLK_PERIOD_NS  = 10;
  localparam int          PBR_SOFT_RST_NS    = 160;
  localparam int          PBR_SOFT_RST_CYC   = (PBR_SOFT_RST_NS + PBR_CLK_PERIOD_NS - 1) / PBR_CLK_PERIOD_NS;

  typedef enum logic {PBR_RUN, PBR_RESETTING} pbr_rst_state_t;

endpackage

// *** logic/pbr_regs.sv ***
// Basic control and status registers with link-side datapath controls
`timescale 1ns/100ps
module pbr_regs
  import pbr_pkg::*;
#(
  parameter int SOFT_RST_CYC = PBR_SOFT_RST_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  output logic [15:0]      mgmt_rdata,
  output logic             mgmt_rvalid,
  input  wire logic        power_down_state,
  input  wire logic        negotiation_done,
  input  wire logic [1:0]  neg_speed,
  input  wire logic        neg_full_duplex,
  output logic             core_reset,
  output logic             negotiation_enable,
  output logic             negotiation_restart,
  output logic [1:0]       link_speed,
  output logic             link_full_duplex,
  input  wire logic        clk_link,
  input  wire logic        link_up,
  input  wire logic        jabber_det,
  input  wire logic        remote_fault_det,
  input  wire logic [7:0]  mac_txd,
  input  wire logic        mac_tx_en,
  output logic [7:0]       mac_rxd,
  output logic             mac_rx_dv,
  output logic             mac_col,
  input  wire logic [7:0]  line_rxd,
  input  wire logic        line_rx_dv,
  input  wire logic        line_col,
  output logic [7:0]       line_txd,
  output logic             line_tx_en
);

  // ==========================================================================
  // Declarations
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  function automatic logic [2:0] shift_in(input logic [2:0] s, input logic d);
    shift_in = {s[1:0], d};
  endfunction

  pbr_rst_state_t rst_state_r;
  logic [15:0]    ctrl_r;
  logic           restart_r;
  logic [7:0]     rst_cnt_r;
  logic           pwr_s1_r;
  logic           pwr_s2_r;
  logic           link_lat_r;
  logic           jabber_r;
  logic           rfault_r;
  logic [15:0]    rdata_r;
  logic           rvalid_r;
  logic [1:0]     speed_r;
  logic           duplex_r;
  logic [2:0]     jab_sync_r;
  logic [2:0]     rf_sync_r;
  logic [2:0]     loss_sync_r;
  logic           lup_s1_r;
  logic           lup_s2_r;
  logic           wr_ctrl;
  logic           rd_stat;
  logic           jab_evt;
  logic           rf_evt;
  logic           loss_evt;
  logic [15:0]    status_now;
  logic [1:0]     forced_speed;
  logic           lrst_s1_r;
  logic           lrst_s2_r;
  logic           hrst_s1_r;
  logic           hrst_s2_r;
  logic           lb_s1_r;
  logic           lb_s2_r;
  logic           iso_s1_r;
  logic           iso_s2_r;
  logic           ct_s1_r;
  logic           ct_s2_r;
  logic           jab_tgl_r;
  logic           rf_tgl_r;
  logic           loss_tgl_r;
  logic           lup_d_r;
  logic [7:0]     mac_rxd_r;
  logic           mac_rx_dv_r;
  logic           mac_col_r;
  logic [7:0]     line_txd_r;
  logic           line_tx_en_r;

  // ==========================================================================
  // Management access decode
  always_comb begin
    wr_ctrl = mgmt_wr && hit(mgmt_addr, PBR_ADDR_CONTROL) && (rst_state_r == PBR_RUN);
    rd_stat = mgmt_rd && hit(mgmt_addr, PBR_ADDR_STATUS);
    jab_evt = jab_sync_r[2] ^ jab_sync_r[1];
    rf_evt = rf_sync_r[2] ^ rf_sync_r[1];
    loss_evt = loss_sync_r[2] ^ loss_sync_r[1];
    forced_speed = {ctrl_r[PBR_C_SPEED_MSB], ctrl_r[PBR_C_SPEED_LSB]};
  end

  // ==========================================================================
  // Soft reset sequencer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_state_r <= PBR_RUN;
      rst_cnt_r <= 8'h00;
    end else begin
      case (rst_state_r)
        PBR_RUN: begin
          if (wr_ctrl && mgmt_wdata[PBR_C_SOFT_RESET]) begin
            rst_state_r <= PBR_RESETTING;
            rst_cnt_r <= 8'(SOFT_RST_CYC - 1);
          end
        end
        PBR_RESETTING: begin
          if (rst_cnt_r == 8'h00) begin
            rst_state_r <= PBR_RUN;
          end else begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
          end
        end
        default: begin
          rst_state_r <= PBR_RUN;
        end
      endcase
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge clk_sys) begin
    if (srst || rst_state_r == PBR_RESETTING) begin
      ctrl_r <= PBR_CONTROL_RESET;
    end else if (wr_ctrl) begin
      ctrl_r <= (mgmt_wdata & PBR_CONTROL_WMASK) | (ctrl_r & ~PBR_CONTROL_WMASK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || rst_state_r == PBR_RESETTING) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= wr_ctrl && mgmt_wdata[PBR_C_NEG_RESTART] && !mgmt_wdata[PBR_C_SOFT_RESET];
    end
  end

  // ==========================================================================
  // Effective link mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      speed_r <= PBR_SPEED_1000;
      duplex_r <= 1'b1;
    end else if (ctrl_r[PBR_C_NEG_ENABLE]) begin
      speed_r <= neg_speed;
      duplex_r <= neg_full_duplex;
    end else begin
      if (forced_speed != PBR_SPEED_RSVD) begin
        speed_r <= forced_speed;
      end
      duplex_r <= ctrl_r[PBR_C_DUPLEX];
    end
  end

  // ==========================================================================
  // Inputs from other domains
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
      lup_s1_r <= 1'b0;
      lup_s2_r <= 1'b0;
      jab_sync_r <= 3'h0;
      rf_sync_r <= 3'h0;
      loss_sync_r <= 3'h0;
    end else begin
      pwr_s1_r <= power_down_state;
      pwr_s2_r <= pwr_s1_r;
      lup_s1_r <= link_up;
      lup_s2_r <= lup_s1_r;
      jab_sync_r <= shift_in(jab_sync_r, jab_tgl_r);
      rf_sync_r <= shift_in(rf_sync_r, rf_tgl_r);
      loss_sync_r <= shift_in(loss_sync_r, loss_tgl_r);
    end
  end

  // ==========================================================================
  // Status flags
  always_ff @(posedge clk_sys) begin
    if (srst || rst_state_r == PBR_RESETTING) begin
      link_lat_r <= 1'b0;
    end else if (loss_evt || !lup_s2_r) begin
      link_lat_r <= 1'b0;
    end else if (rd_stat) begin
      link_lat_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || rst_state_r == PBR_RESETTING) begin
      jabber_r <= 1'b0;
    end else if (jab_evt) begin
      jabber_r <= 1'b1;
    end else if (rd_stat) begin
      jabber_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || rst_state_r == PBR_RESETTING) begin
      rfault_r <= 1'b0;
    end else if (rf_evt) begin
      rfault_r <= 1'b1;
    end else if (rd_stat) begin
      rfault_r <= 1'b0;
    end
  end

  always_comb begin
    status_now = PBR_STATUS_FIXED;
    status_now[PBR_S_NEG_DONE] = negotiation_done && ctrl_r[PBR_C_NEG_ENABLE];
    status_now[PBR_S_REMOTE_FAULT] = rfault_r;
    status_now[PBR_S_LINK_UP] = link_lat_r;
    status_now[PBR_S_JABBER] = jabber_r;
  end

  // ==========================================================================
  // Read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= mgmt_rd;
      if (mgmt_rd) begin
        if (hit(mgmt_addr, PBR_ADDR_CONTROL)) begin
          rdata_r <= {rst_state_r == PBR_RESETTING, ctrl_r[14:12], pwr_s2_r,
                      ctrl_r[10], restart_r, ctrl_r[8:6], 6'h00};
        end else if (rd_stat) begin
          rdata_r <= status_now;
        end else begin
          rdata_r <= 16'h0000;
        end
      end
    end
  end

  assign mgmt_rdata          = rdata_r;
  assign mgmt_rvalid         = rvalid_r;
  assign core_reset          = (rst_state_r == PBR_RESETTING);
  assign negotiation_enable  = ctrl_r[PBR_C_NEG_ENABLE];
  assign negotiation_restart = restart_r;
  assign link_speed          = speed_r;
  assign link_full_duplex    = duplex_r;

  // ==========================================================================
  // Link domain: control synchronisers
  always_ff @(posedge clk_link) begin
    lrst_s1_r <= srst || (rst_state_r == PBR_RESETTING);
    lrst_s2_r <= lrst_s1_r;
    hrst_s1_r <= srst;
    hrst_s2_r <= hrst_s1_r;
  end

  always_ff @(posedge clk_link) begin
    if (lrst_s2_r) begin
      lb_s1_r <= 1'b0;
      lb_s2_r <= 1'b0;
      iso_s1_r <= 1'b0;
      iso_s2_r <= 1'b0;
      ct_s1_r <= 1'b0;
      ct_s2_r <= 1'b0;
    end else begin
      lb_s1_r <= ctrl_r[PBR_C_LOOPBACK];
      lb_s2_r <= lb_s1_r;
      iso_s1_r <= ctrl_r[PBR_C_ISOLATE];
      iso_s2_r <= iso_s1_r;
      ct_s1_r <= ctrl_r[PBR_C_COL_TEST];
      ct_s2_r <= ct_s1_r;
    end
  end

  // ==========================================================================
  // Link domain: event toggles
  always_ff @(posedge clk_link) begin
    // Hardware reset only, so a soft reset makes no false events
    if (hrst_s2_r) begin
      jab_tgl_r <= 1'b0;
      rf_tgl_r <= 1'b0;
      loss_tgl_r <= 1'b0;
      lup_d_r <= 1'b0;
    end else begin
      lup_d_r <= link_up;
      if (jabber_det) begin
        jab_tgl_r <= !jab_tgl_r;
      end
      if (remote_fault_det) begin
        rf_tgl_r <= !rf_tgl_r;
      end
      if (lup_d_r && !link_up) begin
        loss_tgl_r <= !loss_tgl_r;
      end
    end
  end

  // ==========================================================================
  // Link domain: MAC datapath
  always_ff @(posedge clk_link) begin
    if (lrst_s2_r || iso_s2_r) begin
      mac_rxd_r <= 8'h00;
      mac_rx_dv_r <= 1'b0;
      mac_col_r <= 1'b0;
      line_txd_r <= 8'h00;
      line_tx_en_r <= 1'b0;
    end else begin
      mac_rxd_r <= lb_s2_r ? mac_txd : line_rxd;
      mac_rx_dv_r <= lb_s2_r ? mac_tx_en : line_rx_dv;
      mac_col_r <= ct_s2_r ? mac_tx_en : (line_col && !lb_s2_r);
      line_txd_r <= lb_s2_r ? 8'h00 : mac_txd;
      line_tx_en_r <= mac_tx_en && !lb_s2_r;
    end
  end

  assign mac_rxd    = mac_rxd_r;
  assign mac_rx_dv  = mac_rx_dv_r;
  assign mac_col    = mac_col_r;
  assign line_txd   = line_txd_r;
  assign line_tx_en = line_tx_en_r;

endmodule // pbr_regs

// *** verif/pbr_regs_sva.sv ***
// Assertions for the basic control and status register bank
`timescale 1ns/100ps
module pbr_regs_sva
  import pbr_pkg::*;
#(
  parameter int SOFT_RST_CYC = PBR_SOFT_RST_CYC
) (
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic [4:0]  mgmt_addr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic        mgmt_wr,
  input wire logic        mgmt_rd,
  input wire logic [15:0] mgmt_rdata,
  input wire logic        mgmt_rvalid,
  input wire logic        negotiation_done,
  input wire logic [1:0]  neg_speed,
  input wire logic        neg_full_duplex,
  input wire logic        core_reset,
  input wire logic        negotiation_enable,
  input wire logic        negotiation_restart,
  input wire logic [1:0]  link_speed,
  input wire logic        link_full_duplex
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] rst_cnt_r;
  always_ff @(posedge clk_sys) begin
    if (srst || !core_reset) rst_cnt_r <= 8'h00;
    else rst_cnt_r <= rst_cnt_r + 8'h01;
  end
  // ==========================================
  // Sequences
  sequence s_ctrl_wr;
    mgmt_wr && mgmt_addr == PBR_ADDR_CONTROL && !core_reset;
  endsequence
  sequence s_rd_of(logic [4:0] a);
    mgmt_rvalid && $past(mgmt_addr) == a;
  endsequence
  // ==========================================
  // Properties
  a_rvalid_timing: assert property (!$past(srst) |-> mgmt_rvalid == $past(mgmt_rd))
    else $error("read answer not one cycle after request");
  a_status_fixed: assert property (s_rd_of(PBR_ADDR_STATUS) |->
    (mgmt_rdata & PBR_STATUS_FIXED) == PBR_STATUS_FIXED)
    else $error("status ability bits not one");
  a_status_rsvd: assert property (s_rd_of(PBR_ADDR_STATUS) |-> (mgmt_rdata & 16'h8680) == 16'h0000)
    else $error("status reserved bits not zero");
  a_ctrl_low_bits: assert property (s_rd_of(PBR_ADDR_CONTROL) |-> mgmt_rdata[6:0] == 7'h40)
    else $error("control low bits wrong");
  a_unmapped_zero: assert property (mgmt_rvalid && $past(mgmt_addr) > 5'h01 |-> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_soft_rst_start: assert property (s_ctrl_wr ##0 mgmt_wdata[15] |=> core_reset)
    else $error("soft reset did not start");
  a_soft_rst_len: assert property ($fell(core_reset) |-> rst_cnt_r == SOFT_RST_CYC)
    else $error("soft reset length wrong");
  a_restart_pulse: assert property (s_ctrl_wr ##0 (mgmt_wdata[9] && !mgmt_wdata[15])
    |=> negotiation_restart ##1 !negotiation_restart)
    else $error("restart pulse wrong");
  a_enable_follow: assert property (s_ctrl_wr ##0 !mgmt_wdata[15]
    |=> negotiation_enable == $past(mgmt_wdata[PBR_C_NEG_ENABLE]))
    else $error("negotiation enable not written");
  a_neg_copy: assert property (negotiation_enable && $past(negotiation_enable) && !$past(srst)
    |-> link_speed == $past(neg_speed) && link_full_duplex == $past(neg_full_duplex))
    else $error("negotiated result not used");
  a_done_bit: assert property (s_rd_of(PBR_ADDR_STATUS) ##0 mgmt_rdata[PBR_S_NEG_DONE]
    |-> $past(negotiation_done))
    else $error("done bit without completion");
endmodule // pbr_regs_sva

bind pbr_regs pbr_regs_sva #(.SOFT_RST_CYC(SOFT_RST_CYC)) pbr_regs_sva_i (.clk_sys(clk_sys), .srst(srst),
  .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .negotiation_done(negotiation_done),
  .neg_speed(neg_speed), .neg_full_duplex(neg_full_duplex), .core_reset(core_reset),
  .negotiation_enable(negotiation_enable), .negotiation_restart(negotiation_restart),
  .link_speed(link_speed), .link_full_duplex(link_full_duplex));

// *** verif/pbr_link_model.sv ***
// Link-side partner: link state, fault pulses, MAC and line data
`timescale 1ns/100ps
module pbr_link_model (
  input  wire logic  clk_link,
  input  wire logic  link_ok,
  input  wire logic  jab_go,
  input  wire logic  fault_go,
  output logic       link_up,
  output logic       jabber_det,
  output logic       remote_fault_det,
  output logic [7:0] mac_txd,
  output logic       mac_tx_en,
  output logic [7:0] line_rxd,
  output logic       line_rx_dv,
  output logic       line_col
);
  logic jab_q_r = 1'b0;
  logic fault_q_r = 1'b0;
  // One-cycle event pulses on each toggle request
  always_ff @(posedge clk_link) begin
    link_up <= link_ok;
    jab_q_r <= jab_go;
    fault_q_r <= fault_go;
    jabber_det <= jab_go ^ jab_q_r;
    remote_fault_det <= fault_go ^ fault_q_r;
  end
  assign mac_txd = 8'h5a;
  assign mac_tx_en = 1'b1;
  assign line_rxd = 8'ha5;
  assign line_rx_dv = 1'b1;
  assign line_col = 1'b0;
endmodule // pbr_link_model

// *** verif/tb_top.sv ***
// Self-checking bench for the register bank
`timescale 1ns/100ps
module tb_top;
  import pbr_pkg::*;
  logic        clk_sys = 1'b0;
  logic        clk_link = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic        mgmt_wr, mgmt_rd, mgmt_rvalid, power_down_state, negotiation_done, neg_full_duplex;
  logic        core_reset, negotiation_enable, negotiation_restart, link_full_duplex, link_up;
  logic        jabber_det, remote_fault_det, mac_tx_en, mac_rx_dv, mac_col, line_rx_dv, line_col;
  logic        line_tx_en, link_ok, jab_go, fault_go;
  logic [1:0]  neg_speed, link_speed;
  logic [7:0]  mac_txd, mac_rxd, line_rxd, line_txd;
  int          err_count = 0;
  int          comparisons = 0;
  int          i;

  initial forever #5 clk_sys = ~clk_sys;
  initial begin
    #3;
    forever #16 clk_link = ~clk_link;
  end

  pbr_regs #(.SOFT_RST_CYC(2)) pbr_regs_i (.clk_sys(clk_sys), .srst(srst), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .power_down_state(power_down_state), .negotiation_done(negotiation_done),
    .neg_speed(neg_speed), .neg_full_duplex(neg_full_duplex), .core_reset(core_reset),
    .negotiation_enable(negotiation_enable), .negotiation_restart(negotiation_restart),
    .link_speed(link_speed), .link_full_duplex(link_full_duplex), .clk_link(clk_link), .link_up(link_up),
    .jabber_det(jabber_det), .remote_fault_det(remote_fault_det), .mac_txd(mac_txd), .mac_tx_en(mac_tx_en),
    .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv), .mac_col(mac_col), .line_rxd(line_rxd),
    .line_rx_dv(line_rx_dv), .line_col(line_col), .line_txd(line_txd), .line_tx_en(line_tx_en));

  pbr_link_model pbr_link_model_i (.clk_link(clk_link), .link_ok(link_ok), .jab_go(jab_go),
    .fault_go(fault_go), .link_up(link_up), .jabber_det(jabber_det), .remote_fault_det(remote_fault_det),
    .mac_txd(mac_txd), .mac_tx_en(mac_tx_en), .line_rxd(line_rxd), .line_rx_dv(line_rx_dv),
    .line_col(line_col));

  // ==========================================
  // Tasks
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] v);
    cyc(1);
    mgmt_addr = a;
    mgmt_wdata = v;
    mgmt_wr = 1'b1;
    cyc(1);
    mgmt_wr = 1'b0;
  endtask
  task automatic rdc(logic [4:0] a, logic [15:0] exp);
    cyc(1);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    cyc(1);
    mgmt_rd = 1'b0;
    chk("mgmt_rvalid", 16'(mgmt_rvalid), 16'h0001);
    chk("mgmt_rdata", mgmt_rdata, exp);
  endtask
  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  initial begin
    {mgmt_addr, mgmt_wdata, mgmt_wr, mgmt_rd, power_down_state, negotiation_done} = '0;
    {neg_speed, neg_full_duplex, link_ok, jab_go, fault_go} = '0;
    cyc(4);
    srst = 1'b0;
    rdc(PBR_ADDR_CONTROL, PBR_CONTROL_RESET);
    rdc(PBR_ADDR_STATUS, PBR_STATUS_RESET);
    rdc(5'h1f, 16'h0000);
    wr(PBR_ADDR_CONTROL, 16'h7fff);
    cyc(2);
    rdc(PBR_ADDR_CONTROL, 16'h75c0);
    wr(PBR_ADDR_CONTROL, 16'h0000);
    cyc(2);
    chk("link_speed", 16'(link_speed), 16'(PBR_SPEED_1000));
    chk("link_full_duplex", 16'(link_full_duplex), 16'h0000);
    wr(PBR_ADDR_CONTROL, 16'h2100);
    cyc(2);
    chk("link_speed", 16'(link_speed), 16'(PBR_SPEED_1000));
    chk("link_full_duplex", 16'(link_full_duplex), 16'h0001);
    neg_speed = PBR_SPEED_100;
    wr(PBR_ADDR_CONTROL, 16'h1000);
    cyc(2);
    chk("link_speed", 16'(link_speed), 16'(PBR_SPEED_100));
    power_down_state = 1'b1;
    cyc(4);
    rdc(PBR_ADDR_CONTROL, 16'h1840);
    power_down_state = 1'b0;
    negotiation_done = 1'b1;
    link_ok = 1'b1;
    cyc(20);
    rdc(PBR_ADDR_STATUS, 16'h7969);
    rdc(PBR_ADDR_STATUS, 16'h796d);
    link_ok = 1'b0;
    cyc(20);
    link_ok = 1'b1;
    cyc(20);
    rdc(PBR_ADDR_STATUS, 16'h7969);
    rdc(PBR_ADDR_STATUS, 16'h796d);
    jab_go = 1'b1;
    fault_go = 1'b1;
    cyc(20);
    rdc(PBR_ADDR_STATUS, 16'h797f);
    rdc(PBR_ADDR_STATUS, 16'h796d);
    chk("mac_rxd", 16'(mac_rxd), 16'h00a5);
    chk("line_txd", 16'(line_txd), 16'h005a);
    chk("line_tx_en", 16'(line_tx_en), 16'h0001);
    chk("mac_col", 16'(mac_col), 16'h0000);
    wr(PBR_ADDR_CONTROL, 16'h5000);
    cyc(40);
    chk("mac_rxd", 16'(mac_rxd), 16'h005a);
    chk("line_tx_en", 16'(line_tx_en), 16'h0000);
    wr(PBR_ADDR_CONTROL, 16'h1080);
    cyc(40);
    chk("mac_col", 16'(mac_col), 16'h0001);
    wr(PBR_ADDR_CONTROL, 16'h1400);
    cyc(40);
    chk("mac_rx_dv", 16'(mac_rx_dv), 16'h0000);
    chk("mac_rxd", 16'(mac_rxd), 16'h0000);
    wr(PBR_ADDR_CONTROL, 16'h8000);
    chk("core_reset", 16'(core_reset), 16'h0001);
    for (i = 0; i < 50 && core_reset !== 1'b0; i++) cyc(1);
    if (core_reset !== 1'b0) begin
      err_count++;
    end else begin
      rdc(PBR_ADDR_CONTROL, PBR_CONTROL_RESET);
      cyc(20);
      rdc(PBR_ADDR_STATUS, 16'h7969);
    end
    give_verdict();
  end
endmodule // tb_top
